// File: hdl/cfg_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defines.vh"
module cfg_mem (
    input  wire                  i_clk,
    input  wire                  i_rst_n,
    input  wire                  i_we,
    input  wire [`LINE_AW-1:0]   i_waddr,
    input  wire [`CFG_W-1:0]     i_wdata,
    input  wire [`LINE_AW-1:0]   i_raddr,
    output reg  [`CFG_W-1:0]     o_rdata,
    output wire [`N_LINES*`CFG_W-1:0] o_all
);
    genvar g;
    // one config word per line, no field shared between lines
    generate
        for (g = 0; g < `N_LINES; g = g + 1) begin : line
            reg [`CFG_W-1:0] cfg_ff;
            always @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cfg_ff <= `CFG_RESET;
                end else if (i_we && i_waddr == g) begin
                    cfg_ff <= i_wdata;
                end
            end
            assign o_all[g*`CFG_W +: `CFG_W] = cfg_ff;
        end
    endgenerate
    // registered read port
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= `CFG_RESET;
        end else if (i_raddr < `N_LINES) begin
            o_rdata <= o_all[i_raddr*`CFG_W +: `CFG_W];
        end else begin
            o_rdata <= `CFG_RESET;
        end
    end
endmodule
`default_nettype wire

// File: hdl/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defines.vh"
module pin_sync (
    input  wire                  i_clk,
    input  wire                  i_rst_n,
    input  wire [`N_LINES-1:0]   i_pin,
    output wire [`N_LINES-1:0]   o_pin_sync
);
    reg [`N_LINES-1:0] meta_ff;
    reg [`N_LINES-1:0] sync_ff;
    // two-stage synchroniser; first stage feeds only the second
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_ff <= {`N_LINES{1'b0}};
            sync_ff <= {`N_LINES{1'b0}};
        end else begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
        end
    end
    assign o_pin_sync = sync_ff;
endmodule
`default_nettype wire

// File: hdl/port_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defines.vh"
// What this block does
// [RULE1] every line configured separately, per bit
// [RULE2] push/pull or open-drain, pull enable per line
// [RULE3] edge and current settings go to pad
// [RULE4] input direction disables the output driver
// [RULE5] reset forces inputs, pulls off
// [RULE6] each line read and written singly
// [RULE7] 76 lines; input-only ports never drive
// [RULE8] alternate functions, software picks the source
// [RULE9] unclaimed lines act as general purpose I/O
// [RULE10] strong, medium, weak; slow edge in strong
// [RULE11] output latch drives; synced level readable
module port_ctrl (
    input  wire                          i_clk,
    input  wire                          i_rst_n,
    input  wire [`ADDR_W-1:0]            i_addr,
    input  wire [`DATA_W-1:0]            i_wdata,
    input  wire                          i_wr,
    input  wire                          i_rd,
    output reg  [`DATA_W-1:0]            o_rdata,
    input  wire [`N_LINES-1:0]           i_pin,
    output wire [`N_LINES-1:0]           o_pin,
    output wire [`N_LINES-1:0]           o_pin_oe,
    output wire [`N_LINES-1:0]           o_pull_en,
    output wire [`N_LINES-1:0]           o_slow_edge,
    output wire [2*`N_LINES-1:0]         o_drv_str,
    input  wire [`N_ALT_SRC*`N_LINES-1:0] i_alt_out,
    input  wire [`N_ALT_SRC*`N_LINES-1:0] i_alt_oe,
    output wire [`N_LINES-1:0]           o_alt_in
);
    wire [2:0]          sel      = i_addr[`ADDR_W-1:`LINE_AW];
    wire [`LINE_AW-1:0] line     = i_addr[`LINE_AW-1:0];
    wire                line_ok  = (line < `N_LINES);
    wire [`N_LINES*`CFG_W-1:0] cfg_all;
    wire [`CFG_W-1:0]   cfg_rdata;
    wire [`N_LINES-1:0] pin_sync;
    reg  [`N_LINES-1:0] out_ff;
    reg  [`N_LINES*`ALT_SRC_W-1:0] alt_sel_ff;
    reg  [2:0]          rsel_ff;
    reg  [`LINE_AW-1:0] rline_ff;
    reg                 rok_ff;
    reg                 rd_ff;

    // [RULE5] reset clears config: inputs, pulls off
    // [RULE1] per-line config store
    cfg_mem u_cfg (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_wr && sel == `SEL_CFG && line_ok),
        .i_waddr (line),
        .i_wdata (i_wdata),
        .i_raddr (line),
        .o_rdata (cfg_rdata),
        .o_all   (cfg_all)
    );

    // [RULE11] pin level synchroniser
    pin_sync u_sync (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_pin      (i_pin),
        .o_pin_sync (pin_sync)
    );

    // [RULE6] single-line writes: one output latch bit or one 2-bit alt select field
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            out_ff     <= {`N_LINES{1'b0}};
            alt_sel_ff <= {(`N_LINES*`ALT_SRC_W){1'b0}};
        end else if (i_wr && line_ok) begin
            if (sel == `SEL_OUT) begin
                out_ff[line] <= i_wdata[0];
            end else if (sel == `SEL_ALT) begin
                alt_sel_ff[line*`ALT_SRC_W +: `ALT_SRC_W] <=
                    i_wdata[`ALT_SRC_W-1:0];
            end
        end
    end

    // read capture; data stand exactly one cycle after the strobe
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            rsel_ff  <= 3'h0;
            rline_ff <= {`LINE_AW{1'b0}};
            rok_ff   <= 1'b0;
            rd_ff    <= 1'b0;
        end else begin
            rsel_ff  <= sel;
            rline_ff <= line;
            rok_ff   <= line_ok;
            rd_ff    <= i_rd;
        end
    end

    reg [`DATA_W-1:0] nxt_rdata;
    reg               bit_out;
    reg               bit_in;
    reg [`ALT_SRC_W-1:0] alt_rd;
    // read mux; unmapped lines and selectors read zero
    always @* begin
        bit_out   = out_ff[rline_ff];
        bit_in    = pin_sync[rline_ff];
        alt_rd    = alt_sel_ff[rline_ff*`ALT_SRC_W +: `ALT_SRC_W];
        nxt_rdata = {`DATA_W{1'b0}};
        if (!rd_ff || !rok_ff) begin
            nxt_rdata = {`DATA_W{1'b0}};
        end else if (rsel_ff == `SEL_CFG) begin
            nxt_rdata = cfg_rdata;
        end else if (rsel_ff == `SEL_OUT) begin
            nxt_rdata = {{(`DATA_W-1){1'b0}}, bit_out};
        // [RULE11] synced level in any direction
        end else if (rsel_ff == `SEL_IN) begin
            nxt_rdata = {{(`DATA_W-1){1'b0}}, bit_in};
        end else if (rsel_ff == `SEL_ALT) begin
            nxt_rdata = {{(`DATA_W-`ALT_SRC_W){1'b0}}, alt_rd};
        end
    end
    always @* begin
        o_rdata = nxt_rdata;
    end

    // per-line pad control
    genvar g;
    generate
        for (g = 0; g < `N_LINES; g = g + 1) begin : pad
            wire [`CFG_W-1:0] c = cfg_all[g*`CFG_W +: `CFG_W];
            wire [1:0] drv = c[`CFG_DRV_HI:`CFG_DRV_LO];
            wire [`ALT_SRC_W-1:0] s =
                alt_sel_ff[g*`ALT_SRC_W +: `ALT_SRC_W];
            // [RULE8] software-chosen alternate source
            wire a_val = i_alt_out[g*`N_ALT_SRC + s];
            wire a_oe  = i_alt_oe[g*`N_ALT_SRC + s];
            // [RULE9] latch used unless alternate claims line
            wire val   = c[`CFG_ALT] ? a_val : out_ff[g];
            wire want  = c[`CFG_ALT] ? a_oe  : 1'b1;
            // one wire per line keeps every net single-driven
            wire pin_val = c[`CFG_OD] ? 1'b0 : val;
            // [RULE4] input direction floats the pin
            // [RULE2] open-drain drives only the low level
            wire pin_oe  = c[`CFG_DIR] & want & (~c[`CFG_OD] | ~val);
            if (g < `N_BIDIR) begin : bidir
                assign o_pin[g]    = pin_val;
                assign o_pin_oe[g] = pin_oe;
            end else begin : inonly
                // [RULE7] input-only lines never drive
                assign o_pin[g]    = 1'b0;
                assign o_pin_oe[g] = 1'b0;
            end
            // [RULE2] pull device per line
            assign o_pull_en[g] = c[`CFG_PULL];
            // [RULE10] slow edge only honoured in strong mode
            assign o_slow_edge[g] = c[`CFG_EDGE] && drv == `DRV_STRONG;
            // [RULE3] current setting passed to pad
            assign o_drv_str[2*g +: 2] = (drv > `DRV_WEAK) ? `DRV_WEAK : drv;
            assign o_alt_in[g] = pin_sync[g];
        end
    endgenerate
endmodule
`default_nettype wire

// File: hdl/port_ctrl_defines.vh
`ifndef PORT_CTRL_DEFINES_VH
`define PORT_CTRL_DEFINES_VH
// line counts and port grouping
`define N_LINES      76
`define N_BIDIR      60
`define LINE_AW      7
// per-line register index space: line number in low bits, field select above
`define SEL_CFG      3'h0
`define SEL_OUT      3'h1
`define SEL_IN       3'h2
`define SEL_ALT      3'h3
// config word field positions
`define CFG_W        8
`define CFG_DIR      0
`define CFG_OD       1
`define CFG_PULL     2
`define CFG_EDGE     3
`define CFG_DRV_LO   4
`define CFG_DRV_HI   5
`define CFG_ALT      6
`define CFG_RESET    8'h00
// alternate source select width and count
`define ALT_SRC_W    2
`define N_ALT_SRC    4
// driver strength codes
`define DRV_STRONG   2'h0
`define DRV_MEDIUM   2'h1
`define DRV_WEAK     2'h2
`define ADDR_W       10
`define DATA_W       8
`endif

// File: testbench/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire logic        i_clk,
    input  wire logic [75:0] i_drv,
    input  wire logic [75:0] i_oe,
    input  wire logic [75:0] i_pull,
    input  wire logic [75:0] i_ext_en,
    input  wire logic [75:0] i_ext_val,
    output var  logic [75:0] o_lvl
);
    logic flt_ff = 1'b0;
    // a floating line wanders, so a stale level never looks valid
    always @(posedge i_clk) flt_ff <= ~flt_ff;
    // pull device taken as a pull-up
    always_comb
        for (int k = 0; k < 76; k++)
            o_lvl[k] = i_oe[k] ? i_drv[k] : i_ext_en[k] ? i_ext_val[k] :
                       i_pull[k] ? 1'b1 : flt_ff;
endmodule
`default_nettype wire

// File: testbench/port_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_monitor (
    input wire logic         i_clk,
    input wire logic         i_rst_n,
    input wire logic [9:0]   i_addr,
    input wire logic [7:0]   i_wdata,
    input wire logic         i_wr,
    input wire logic         i_rd,
    input wire logic [7:0]   o_rdata,
    input wire logic [75:0]  o_pin_oe,
    input wire logic [75:0]  o_pull_en,
    input wire logic [75:0]  o_slow_edge,
    input wire logic [151:0] o_drv_str
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic bad;
    wire  w0 = i_wr && i_addr == 10'h000;
    // slow edge is only legal on a strong driver
    always_comb begin
        bad = 1'b0;
        for (int k = 0; k < 76; k++)
            if (o_slow_edge[k] && o_drv_str[2*k+:2] != 2'h0) bad = 1'b1;
    end
    chk_reset_quiet: assert property (disable iff (1'b0)
        !i_rst_n |=> o_pin_oe == 0 && o_pull_en == 0)
        else $error("pins active after reset");
    chk_inonly_oe: assert property (o_pin_oe[75:60] == 16'h0000)
        else $error("input-only line driven");
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data without read");
    chk_refused_read: assert property (
        i_rd && i_addr[9:7] > 3'h3 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_input_hiz: assert property (w0 && !i_wdata[0] |=> !o_pin_oe[0])
        else $error("input line still driven");
    chk_pull_write: assert property (w0 |=>
        o_pull_en[0] == $past(i_wdata[2]) && $stable(o_pull_en[75:1]))
        else $error("pull setting wrong");
    chk_drv_pass: assert property (w0 |=> o_drv_str[1:0] ==
        ($past(i_wdata[5:4]) == 2'h3 ? 2'h2 : $past(i_wdata[5:4])))
        else $error("drive code not passed");
    chk_slow_strong: assert property (!bad)
        else $error("slow edge off strong");
    cov_out_write: cover property (i_wr && i_addr[9:7] == 3'h1);
    cov_slow: cover property (o_slow_edge[7]);
    cov_refused: cover property (i_rd && i_addr[9:7] == 3'h4);
endmodule
bind port_ctrl port_ctrl_monitor i_mon (.*);
`default_nettype wire

// File: testbench/port_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defines.vh"
module port_ctrl_test;
    logic         i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
    logic [9:0]   i_addr = 0;
    logic [7:0]   i_wdata = 0, o_rdata;
    logic [75:0]  i_pin, o_pin, oe, pull, slow, a_in, x_en = 0, x_v = 0;
    logic [151:0] drv;
    logic [303:0] a_out = 0, a_oe = 0;
    int           err_count = 0, n_tests = 0;
    always #12.5 i_clk = ~i_clk;
    port_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(oe), .o_pull_en(pull),
        .o_slow_edge(slow), .o_drv_str(drv), .i_alt_out(a_out),
        .i_alt_oe(a_oe), .o_alt_in(a_in));
    board_model i_brd (.i_clk(i_clk), .i_drv(o_pin), .i_oe(oe),
        .i_pull(pull), .i_ext_en(x_en), .i_ext_val(x_v), .o_lvl(i_pin));
    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // one-cycle strobes; the edge after them lands before any check
    task wr(input [2:0] s, input [6:0] n, input [7:0] d);
        @(posedge i_clk);
        i_wr <= 1;
        i_addr <= {s, n};
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 0;
        #1;
    endtask
    task rd(input [2:0] s, input [6:0] n, input [7:0] e, input string m);
        @(posedge i_clk);
        i_rd <= 1;
        i_addr <= {s, n};
        @(posedge i_clk);
        i_rd <= 0;
        #1 chk(o_rdata === e, m);
    endtask
    task summarize;
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // cut a hang short well past the expected run
    initial begin
        #20000;
        err_count++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1;
        #1 chk(oe === 0 && pull === 0 && slow === 0, "reset pads");
        rd(`SEL_CFG, 5, `CFG_RESET, "cfg reset");
        wr(`SEL_CFG, 5, 8'h01);
        wr(`SEL_OUT, 5, 8'h01);
        chk(oe[5] === 1 && o_pin[5] === 1 && oe[4] === 0, "gpio out");
        wr(`SEL_OUT, 4, 8'h01);
        chk(oe[4] === 0 && o_pin[5] === 1, "single bit");
        rd(`SEL_IN, 5, 8'h01, "pin readback");
        rd(`SEL_OUT, 5, 8'h01, "latch readback");
        wr(`SEL_CFG, 5, 8'h03);
        chk(oe[5] === 0, "od high released");
        wr(`SEL_OUT, 5, 8'h00);
        chk(oe[5] === 1 && o_pin[5] === 0, "od low driven");
        wr(`SEL_CFG, 5, 8'h04);
        chk(pull[5] === 1 && oe[5] === 0, "pull input");
        repeat (3) @(posedge i_clk);
        rd(`SEL_IN, 5, 8'h01, "pulled level");
        for (int d = 0; d < 4; d++) begin
            wr(`SEL_CFG, 7, {2'h0, d[1:0], 4'h9});
            chk(drv[15:14] === (d == 3 ? 2'h2 : d[1:0]), "drive");
            chk(slow[7] === (d == 0), "slow edge");
        end
        wr(`SEL_CFG, 70, 8'h01);
        wr(`SEL_OUT, 70, 8'h01);
        chk(oe[75:60] === 16'h0000, "input-only");
        @(posedge i_clk);
        x_en[70] <= 1;
        x_v[70] <= 1;
        repeat (3) @(posedge i_clk);
        rd(`SEL_IN, 70, 8'h01, "input-only read");
        chk(a_in[70] === 1, "alt input");
        wr(`SEL_ALT, 6, 8'h02);
        wr(`SEL_CFG, 6, 8'h41);
        a_out[26] <= 1;
        a_oe[26] <= 1;
        @(posedge i_clk);
        #1 chk(oe[6] === 1 && o_pin[6] === 1, "alt out");
        rd(3'h4, 5, 8'h00, "bad select");
        rd(`SEL_CFG, 76, 8'h00, "bad line");
        i_rst_n <= 0;
        @(posedge i_clk);
        #1 chk(oe === 0 && pull === 0, "mid reset");
        summarize;
    end
endmodule
`default_nettype wire
